/* inc/dcff_pkg.sv */
package dcff_pkg;

  // Data path and memory geometry
  localparam int DATA_W       = 36;
  localparam int SMALL_DEPTH  = 512;
  localparam int LARGE_DEPTH  = 1024;
  localparam int ADDR_W       = 10;
  localparam int PTR_W        = 11;
  localparam int OFFSET_W     = 10;
  localparam int BUF_DEPTH    = 16;

  // Core clock and skew limits in ns
  localparam int CORE_PERIOD_NS = 4;
  localparam int SKEW_ONE_NS    = 5;
  localparam int SKEW_TWO_NS    = 7;

  // Skew limits as whole core cycles, rounded up
  localparam int AGE_W = 3;
  localparam logic [AGE_W-1:0] SKEW_ONE_CYC = AGE_W'((SKEW_ONE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [AGE_W-1:0] SKEW_TWO_CYC = AGE_W'((SKEW_TWO_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // Flag slots of the synchroniser array
  localparam int FLAG_CNT    = 4;
  localparam int FLAG_ROOM   = 0;
  localparam int FLAG_NFULL  = 1;
  localparam int FLAG_NEMPTY = 2;
  localparam int FLAG_NE     = 3;

  // Pin sampler depth
  localparam int PIN_STAGES = 3;

  // Retransmit state
  typedef enum logic [0:0] {
    DCFF_NORMAL = 1'b0,
    DCFF_RETX   = 1'b1
  } dcff_retx_e;

  // Port A control and data pins
  typedef struct packed {
    logic              select_n;
    logic              write_not_read;
    logic              mail_select;
    logic              enable;
    logic [DATA_W-1:0] data;
  } dcff_port_a_s;

  // Port B control pins
  typedef struct packed {
    logic select_n;
    logic read_not_write;
    logic mail_select;
    logic enable;
    logic retransmit_mode;
    logic read_from_mark;
  } dcff_port_b_s;

endpackage : dcff_pkg

/* rtl/dcff_buf.sv */
`timescale 1ns/10ps
module dcff_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int IW = $clog2(DEPTH);
  localparam logic [IW:0] FULL_CNT = (IW + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [IW-1:0]    wr_idx;
  logic [IW-1:0]    rd_idx;
  logic [IW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes from honest full and empty
  assign in_ready_out  = (count != FULL_CNT);
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = store[rd_idx];

  // Storage array, written only on accepted pushes
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      store[wr_idx] <= in_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= IW'(wr_idx + 1'b1);
      end
      if (pop) begin
        rd_idx <= IW'(rd_idx + 1'b1);
      end
      count <= (IW + 1)'(count + {{IW{1'b0}}, push} - {{IW{1'b0}}, pop});
    end
  end

endmodule : dcff_buf

/* rtl/dcff_top.sv */
`timescale 1ns/10ps
// Function
// [RL1] Input-ready rises on the second write edge, or the third when edges are close.
// [RL2] Almost-empty rises on the second read edge, or the third when edges are close.
// [RL3] Almost-full rises on the second write edge after room appears, skew permitting.
// [RL4] Port A FIFO write: select low, write high, mail low, enable high.
// [RL5] Port B FIFO read: select low, read high, mail low, enable high.
// [RL6] Retransmit control uses only retransmit-mode and read-from-mark inputs.
// [RL7] Depth is 512 or 1024 words of 36 bits per variant.
// [RL8] Leaving retransmit releases almost-full through the write-side synchroniser.
// [RL9] Thresholds come from the almost-empty and almost-full offset inputs.
// [RL10] Flags low in their documented fill ranges; ready flags low at full/empty.
// [RL11] Retransmit lifting count above offset raises almost-empty within two read edges.
// [RL12] First word falls through to output; output word not counted.
// [RL13] Retransmit entered with mode and output-ready high, marking output word.
// [RL14] Every flag crosses through two synchronising stages of its destination clock.
module dcff_top
  import dcff_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input  wire logic                core_clk_in,
  input  wire logic                nrst_in,
  input  wire logic                port_a_clock_in,
  input  wire logic                port_b_clock_in,
  input  wire dcff_port_a_s        port_a_pins_in,
  input  wire dcff_port_b_s        port_b_pins_in,
  input  wire logic [OFFSET_W-1:0] almost_empty_offset_in,
  input  wire logic [OFFSET_W-1:0] almost_full_offset_in,
  output logic      [DATA_W-1:0]   port_b_data_out,
  output logic                     input_ready_flag_out,
  output logic                     almost_full_flag_n_out,
  output logic                     output_ready_flag_out,
  output logic                     almost_empty_flag_n_out
);

  // [RL7] Variant depth
  localparam logic [PTR_W-1:0]  DEPTH     = LARGE_VARIANT ? PTR_W'(LARGE_DEPTH) : PTR_W'(SMALL_DEPTH);
  localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'(DEPTH - 1'b1);
  localparam logic [FLAG_CNT-1:0][AGE_W-1:0] SKEW_SEL = {SKEW_ONE_CYC, SKEW_TWO_CYC, SKEW_TWO_CYC, SKEW_ONE_CYC};

  logic [PIN_STAGES-1:0] a_clk_sync;
  logic [PIN_STAGES-1:0] b_clk_sync;
  logic                  a_clk_lvl;
  logic                  b_clk_lvl;
  logic                  a_rise;
  logic                  b_rise;
  dcff_port_a_s          pa_q [PIN_STAGES];
  dcff_port_b_s          pb_q [PIN_STAGES];
  dcff_port_a_s          pa;
  dcff_port_b_s          pb;
  logic [DATA_W-1:0]     mem [LARGE_DEPTH];
  logic [PTR_W-1:0]      wptr;
  logic [PTR_W-1:0]      rptr_cur;
  logic [PTR_W-1:0]      shadow;
  logic [PTR_W-1:0]      rptr_used;
  logic [PTR_W-1:0]      count_w;
  logic [PTR_W-1:0]      count_r;
  dcff_retx_e            retx_state;
  logic                  ovalid;
  logic                  wr_req;
  logic                  rd_req;
  logic                  mark_reload;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  logic                  buf_out_ready;
  logic [DATA_W-1:0]     buf_out_data;
  logic [FLAG_CNT-1:0]   raw;
  logic [FLAG_CNT-1:0]   dst_en;
  logic [FLAG_CNT-1:0]   flag;
  logic [FLAG_CNT-1:0]   st1;
  logic [FLAG_CNT-1:0]   st2;

  // Port clock samplers; a change counts once stages two and three agree
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_clk_sync <= '0;
      b_clk_sync <= '0;
      a_clk_lvl  <= 1'b0;
      b_clk_lvl  <= 1'b0;
    end else begin
      a_clk_sync <= {a_clk_sync[PIN_STAGES-2:0], port_a_clock_in};
      b_clk_sync <= {b_clk_sync[PIN_STAGES-2:0], port_b_clock_in};
      if (a_clk_sync[1] == a_clk_sync[2]) begin
        a_clk_lvl <= a_clk_sync[2];
      end
      if (b_clk_sync[1] == b_clk_sync[2]) begin
        b_clk_lvl <= b_clk_sync[2];
      end
    end
  end

  assign a_rise = (a_clk_sync[1] == a_clk_sync[2]) & a_clk_sync[2] & ~a_clk_lvl;
  assign b_rise = (b_clk_sync[1] == b_clk_sync[2]) & b_clk_sync[2] & ~b_clk_lvl;

  // Control and data pins delayed to stay aligned with their sampled clocks
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < PIN_STAGES; i++) begin
        pa_q[i] <= '{select_n: 1'b1, default: '0};
        pb_q[i] <= '{select_n: 1'b1, default: '0};
      end
    end else begin
      pa_q[0] <= port_a_pins_in;
      pb_q[0] <= port_b_pins_in;
      for (int i = 1; i < PIN_STAGES; i++) begin
        pa_q[i] <= pa_q[i-1];
        pb_q[i] <= pb_q[i-1];
      end
    end
  end

  assign pa = pa_q[PIN_STAGES-1];
  assign pb = pb_q[PIN_STAGES-1];

  // [RL4] FIFO write pattern on port A
  assign wr_req = a_rise & ~pa.select_n & pa.write_not_read & ~pa.mail_select & pa.enable & input_ready_flag_out;
  // [RL5] FIFO read pattern on port B
  assign rd_req = b_rise & ~pb.select_n & pb.read_not_write & ~pb.mail_select & pb.enable & ovalid;
  // [RL6] Retransmit loop from mode and mark inputs only
  assign mark_reload = b_rise & (retx_state == DCFF_RETX) & pb.retransmit_mode & pb.read_from_mark;

  // Write staging buffer between port A and the memory
  dcff_buf #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (wr_req),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (pa.data),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (buf_out_ready),
    .out_data_out  (buf_out_data)
  );

  // [RL7] Drain only while the memory holds fewer than depth words
  assign buf_out_ready = (count_w < DEPTH);

  // Memory array
  always_ff @(posedge core_clk_in) begin
    if (buf_out_valid & buf_out_ready) begin
      mem[wptr[ADDR_W-1:0] & ADDR_MASK] <= buf_out_data;
    end
  end

  // Write pointer
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr <= '0;
    end else if (buf_out_valid & buf_out_ready) begin
      wptr <= PTR_W'(wptr + 1'b1);
    end
  end

  // [RL13] Retransmit entry marks the output word; exit on mode low
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      retx_state <= DCFF_NORMAL;
      shadow     <= '0;
    end else if (b_rise) begin
      unique case (retx_state)
        DCFF_NORMAL: begin
          if (pb.retransmit_mode & ovalid) begin
            retx_state <= DCFF_RETX;
            shadow     <= PTR_W'(rptr_cur - 1'b1);
          end
        end
        DCFF_RETX: begin
          if (!pb.retransmit_mode) begin
            retx_state <= DCFF_NORMAL;
          end
        end
      endcase
    end
  end

  // [RL8] Write side counts from the shadow pointer while retransmitting
  assign rptr_used = (retx_state == DCFF_RETX) ? shadow : rptr_cur;
  assign count_w   = PTR_W'(wptr - rptr_used);
  // [RL12] Output register word is excluded from the read count
  assign count_r   = PTR_W'(wptr - rptr_cur);

  // [RL12] Output register with fall-through load and retransmit reload
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ovalid          <= 1'b0;
      rptr_cur        <= '0;
      port_b_data_out <= '0;
    end else if (mark_reload) begin
      port_b_data_out <= mem[shadow[ADDR_W-1:0] & ADDR_MASK];
      rptr_cur        <= PTR_W'(shadow + 1'b1);
      ovalid          <= 1'b1;
    end else if (b_rise & (~ovalid | rd_req)) begin
      if (flag[FLAG_NE] & (count_r != '0)) begin
        port_b_data_out <= mem[rptr_cur[ADDR_W-1:0] & ADDR_MASK];
        rptr_cur        <= PTR_W'(rptr_cur + 1'b1);
        ovalid          <= 1'b1;
      end else if (rd_req) begin
        ovalid <= 1'b0;
      end
    end
  end

  // [RL9] [RL10] [RL11] Raw flag conditions from the offsets and depth
  assign raw[FLAG_ROOM]   = (count_w != DEPTH);
  assign raw[FLAG_NFULL]  = (count_w < PTR_W'(DEPTH - {1'b0, almost_full_offset_in}));
  assign raw[FLAG_NEMPTY] = (count_r > {1'b0, almost_empty_offset_in});
  assign raw[FLAG_NE]     = (count_r != '0);
  assign dst_en           = {b_rise, b_rise, a_rise, a_rise};

  // [RL14] Two-stage flag synchronisers with skew-aware first stage
  for (genvar g = 0; g < FLAG_CNT; g++) begin : g_flag
    logic             raw_q;
    logic             raw_old;
    logic [AGE_W-1:0] age;
    logic             s1;
    logic             s2;

    // Age of the latest raw change in core cycles
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        raw_q   <= 1'b0;
        raw_old <= 1'b0;
        age     <= '0;
      end else if (raw[g] != raw_q) begin
        raw_old <= raw_q;
        raw_q   <= raw[g];
        age     <= '0;
      end else if (age != '1) begin
        age <= AGE_W'(age + 1'b1);
      end
    end

    // [RL1] [RL2] [RL3] A change younger than the skew limit waits one edge
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
      end else if (!raw[g]) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
      end else if (dst_en[g]) begin
        s1 <= (age >= SKEW_SEL[g]) ? raw_q : raw_old;
        s2 <= s1;
      end
    end

    // Stages empty on a low level, so a quick refill still waits two edges
    assign st1[g]  = s1;
    assign st2[g]  = s2;
    assign flag[g] = s2 & raw[g];  // Falls are local and immediate
  end

  assign input_ready_flag_out    = flag[FLAG_ROOM] & buf_in_ready;
  assign almost_full_flag_n_out  = flag[FLAG_NFULL];
  assign almost_empty_flag_n_out = flag[FLAG_NEMPTY];
  assign output_ready_flag_out   = ovalid;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_room_full_low:    assert property (count_w == DEPTH |-> !input_ready_flag_out) // [RL10]
                        else $error("ready at full");
  a_nfull_range_low:  assert property (count_w >= PTR_W'(DEPTH - {1'b0, almost_full_offset_in}) // [RL10]
                                       |-> !almost_full_flag_n_out) else $error("almost-full high");
  a_nempty_range_low: assert property (count_r <= {1'b0, almost_empty_offset_in} |-> !almost_empty_flag_n_out) // [RL10]
                        else $error("almost-empty high");
  a_room_rise_edge:   assert property ($rose(flag[FLAG_ROOM]) |-> $past(a_rise)) // [RL1]
                        else $error("ready off edge");
  a_nempty_rise_edge: assert property ($rose(almost_empty_flag_n_out) |-> $past(b_rise)) // [RL2]
                        else $error("almost-empty off edge");
  a_nfull_rise_edge:  assert property ($rose(almost_full_flag_n_out) |-> $past(a_rise) && $past(st1[FLAG_NFULL])) // [RL3]
                        else $error("almost-full off edge");
  a_sync_two_stg:     assert property ($rose(st2[FLAG_ROOM]) |-> $past(st1[FLAG_ROOM])) // [RL14]
                        else $error("one stage");
  a_depth_cap:        assert property (count_w <= DEPTH) else $error("over depth"); // [RL7]
  a_retx_entry:       assert property (b_rise && retx_state == DCFF_NORMAL && pb.retransmit_mode && ovalid // [RL13]
                                       |=> retx_state == DCFF_RETX && shadow == PTR_W'($past(rptr_cur) - 1'b1))
                        else $error("entry missed");
  a_mark_reload:      assert property (mark_reload |=> ovalid && rptr_cur == PTR_W'($past(shadow) + 1'b1)) // [RL6]
                        else $error("reload missed");
  a_fall_through:     assert property (b_rise && !ovalid && !mark_reload && flag[FLAG_NE] && count_r != '0 // [RL12]
                                       |=> ovalid) else $error("no fall through");
  a_write_pattern:    assert property (wr_req |-> !pa.select_n && pa.write_not_read && !pa.mail_select) // [RL4]
                        else $error("bad write");

  c_fall_through:   cover property (b_rise && !ovalid ##1 ovalid);
  c_retx_loop:      cover property (mark_reload);
  c_almost_full:    cover property ($fell(almost_full_flag_n_out));
  c_retx_exit_full: cover property (retx_state == DCFF_RETX ##1 retx_state == DCFF_NORMAL
                                    ##[1:200] $rose(almost_full_flag_n_out));

endmodule : dcff_top

/* verification/dcff_host_model.sv */
`timescale 1ns/10ps
module dcff_host_model
  import dcff_pkg::*;
(
  input  wire logic    core_clk_in,
  output logic         port_a_clock_out,
  output logic         port_b_clock_out,
  output dcff_port_a_s port_a_pins_out,
  output dcff_port_b_s port_b_pins_out
);
  // Clocks low, both ports deselected
  initial begin
    port_a_clock_out = 1'b0;
    port_b_clock_out = 1'b0;
    port_a_pins_out  = {4'h8, 36'h0};
    port_b_pins_out  = 6'h20;
  end

  // Step n core edges, then move off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : hold

  // Port A FIFO access
  // Pins settle while the clock is low and hold past the rise
  task automatic a_cycle(input logic [3:0] ctl, input logic [DATA_W-1:0] d);
    port_a_clock_out = 1'b0;
    port_a_pins_out  = {ctl, d};
    hold(3);
    port_a_clock_out = 1'b1;
    hold(4);
    port_a_pins_out  = {4'h8, ~d};  // Released bus shows the inverse
    hold(1);
  endtask : a_cycle

  task automatic b_cycle(input logic [5:0] ctl);
    port_b_clock_out = 1'b0;
    port_b_pins_out  = ctl;
    hold(3);
    port_b_clock_out = 1'b1;
    hold(4);
    port_b_pins_out  = {4'h8, ctl[1:0]};
    hold(1);
  endtask : b_cycle
endmodule : dcff_host_model

/* verification/dcff_top_tb_top.sv */
`timescale 1ns/10ps
module dcff_top_tb_top;
  import dcff_pkg::*;
  localparam int DEPTH = SMALL_DEPTH;
  localparam int LIMIT = 40000;
  logic                core_clk_in;
  logic                nrst_in;
  logic                port_a_clock;
  logic                port_b_clock;
  dcff_port_a_s        port_a_pins;
  dcff_port_b_s        port_b_pins;
  logic [OFFSET_W-1:0] empty_offset;
  logic [OFFSET_W-1:0] full_offset;
  logic [DATA_W-1:0]   port_b_data;
  logic                input_ready;
  logic                almost_full_n;
  logic                output_ready;
  logic                almost_empty_n;
  logic                retx_mode;
  logic [DATA_W-1:0]   words[$];
  int                  h;
  int                  mark;
  int                  cycles;
  int                  n_mismatch;
  int                  comparisons;
  logic [3:0]          bad[4] = '{4'hD, 4'h1, 4'h7, 4'h4};

  dcff_top #(.LARGE_VARIANT(1'b0)) i_dut (
    .core_clk_in             (core_clk_in),
    .nrst_in                 (nrst_in),
    .port_a_clock_in         (port_a_clock),
    .port_b_clock_in         (port_b_clock),
    .port_a_pins_in          (port_a_pins),
    .port_b_pins_in          (port_b_pins),
    .almost_empty_offset_in  (empty_offset),
    .almost_full_offset_in   (full_offset),
    .port_b_data_out         (port_b_data),
    .input_ready_flag_out    (input_ready),
    .almost_full_flag_n_out  (almost_full_n),
    .output_ready_flag_out   (output_ready),
    .almost_empty_flag_n_out (almost_empty_n)
  );

  dcff_host_model i_host (
    .core_clk_in      (core_clk_in),
    .port_a_clock_out (port_a_clock),
    .port_b_clock_out (port_b_clock),
    .port_a_pins_out  (port_a_pins),
    .port_b_pins_out  (port_b_pins)
  );

  // Core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  // Hang guard
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      results();
    end
  end

  // Words held in memory, output register excluded
  function automatic int stored();
    return (words.size() > h) ? words.size() - h - 1 : 0;
  endfunction : stored

  // Fill levels where a flag should change
  function automatic bit hit();
    int c;
    c = stored();
    return c == empty_offset || c == empty_offset + 1 || c == DEPTH - full_offset - 1 || c == DEPTH - full_offset
           || c >= DEPTH - 1;
  endfunction : hit

  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // Flags against the fill level of the model
  task automatic chk_flags(input logic [3:0] m);
    int         c;
    logic [3:0] e;
    c = stored();
    e = {c < DEPTH, c < DEPTH - full_offset, words.size() > h, c > empty_offset};
    cmp(DATA_W'({input_ready, almost_full_n, output_ready, almost_empty_n} & m), DATA_W'(e & m));
  endtask : chk_flags

  task automatic chk_data();
    cmp(port_b_data, words[h]);
  endtask : chk_data

  function automatic logic [5:0] bctl(input logic [3:0] c, input logic f);
    return {c, retx_mode, f};
  endfunction : bctl

  // One cycle on both ports together
  task automatic step(input logic [3:0] a, input logic [DATA_W-1:0] d, input logic [5:0] b);
    fork
      i_host.a_cycle(a, d);
      i_host.b_cycle(b);
    join
  endtask : step

  task automatic put(input logic [3:0] a);
    logic [DATA_W-1:0] d;
    d = DATA_W'({$urandom, $urandom});
    step(a, d, bctl(4'h8, 1'b0));
    if (a == 4'h5 && stored() < DEPTH) words.push_back(d);
  endtask : put

  task automatic get(input logic [3:0] b);
    if (b == 4'h5) chk_data();
    step(4'h8, DATA_W'($urandom), bctl(b, 1'b0));
    if (b == 4'h5 && words.size() > h) h++;
  endtask : get

  task automatic settle();
    repeat (8) step(4'h8, DATA_W'($urandom), bctl(4'h8, 1'b0));
  endtask : settle

  task automatic fill(input int n);
    repeat (n) begin
      put(4'h5);
      if (hit()) begin
        settle();
        chk_flags(4'hF);
      end
    end
  endtask : fill

  task automatic drain();
    while (words.size() > h) begin
      get(4'h5);
      if (hit()) begin
        settle();
        chk_flags(4'hF);
      end
    end
    settle();
    chk_flags(4'hF);
  endtask : drain

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    void'($urandom(32'h8CE3));
    nrst_in   = 1'b0;
    retx_mode = 1'b0;
    h         = 0;
    empty_offset = OFFSET_W'(1 + $urandom % 5);
    full_offset  = OFFSET_W'(1 + $urandom % 5);
    repeat (4) @(posedge core_clk_in);
    #1;
    cmp(DATA_W'({input_ready, almost_full_n, output_ready, almost_empty_n}), '0);
    cmp(port_b_data, '0);
    repeat (4) @(posedge core_clk_in);
    #1;
    nrst_in = 1'b1;
    settle();
    chk_flags(4'hF);
    $display("test reset done");
    foreach (bad[i]) put(bad[i]);
    settle();
    chk_flags(4'hF);
    put(4'h5);
    settle();
    chk_flags(4'hF);
    fill(DEPTH + 2);
    $display("test fill done");
    foreach (bad[i]) get(bad[i]);
    drain();
    $display("test drain done");
    repeat (empty_offset + 3) put(4'h5);
    settle();
    retx_mode = 1'b1;
    mark      = h;
    step(4'h8, '0, bctl(4'h8, 1'b0));
    repeat (3) get(4'h5);
    settle();
    chk_flags(4'h3);
    step(4'h8, '0, bctl(4'h8, 1'b1));
    h = mark;
    repeat (2) step(4'h8, '0, bctl(4'h8, 1'b0));
    chk_flags(4'h3);
    chk_data();
    retx_mode = 1'b0;
    settle();
    chk_flags(4'hF);
    drain();
    $display("test retransmit done");
    results();
  end
endmodule : dcff_top_tb_top
